// File: twdpl_link.sv
// device end of the two-wire debug packet link, with a small program memory port
// assumes the host drives scl; both pins are open-drain and synchronised here
`include "twdpl_defs.svh"
`default_nettype none
module twdpl_link #(
    parameter int MEM_AW = 8
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    input  wire logic                     scl_in,
    output var  logic                     scl_oe,
    input  wire logic                     sda_in,
    output var  logic                     sda_oe,
    output var  logic                     cmd_active_r,
    output var  logic                     ack_fail_r,
    output var  logic                     mem_busy_r
);
    import twdpl_pkg::*;

    logic [1:0]   scl_s_r, sda_s_r;
    logic         scl_d_r, sda_d_r;
    twdpl_state_t st_r;
    twdpl_phase_t ph_r;
    logic [3:0]   bit_r;
    logic [7:0]   sh_r, cmd_r, tx_r;
    logic [MEM_AW-1:0] addr_r;
    logic [7:0]   mem_r [0:(1<<MEM_AW)-1];
    logic [3:0]   wait_r;
    logic         rx_ok;

    // write-data acknowledge decode, shared by the memory port and the clock stretch
    function automatic logic wr_ack_hit(input twdpl_state_t st,
                                        input logic         rise,
                                        input logic         ok,
                                        input twdpl_phase_t ph,
                                        input logic [7:0]   cmd);
        wr_ack_hit = (st == TWDPL_RACK) && rise && ok && (ph == TWDPL_P_DATA)
                     && (cmd == `TWDPL_CMD_OP_WR);
    endfunction

    // two-flop synchronisers; only the second stage is read
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_s_r <= 2'b11;
            sda_s_r <= 2'b11;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_in};
            sda_s_r <= {sda_s_r[0], sda_in};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    wire scl   = scl_s_r[1];
    wire sda   = sda_s_r[1];
    wire scl_r = scl & ~scl_d_r;
    wire scl_f = ~scl & scl_d_r;
    wire start = scl & scl_d_r & sda_d_r & ~sda;
    wire stop  = scl & scl_d_r & ~sda_d_r & sda;

    // nine received bits must carry an even count of ones
    assign rx_ok = ~(^{sh_r, sda});

    // packet sequencer; a stop always wins, so a retried command starts clean
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= TWDPL_IDLE;
            ph_r <= TWDPL_P_OP;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            cmd_r <= 8'h00;
            tx_r <= 8'h00;
            addr_r <= '0;
            cmd_active_r <= 1'b0;
            ack_fail_r <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop) begin
            st_r <= TWDPL_IDLE;
            cmd_active_r <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start) begin
            st_r <= TWDPL_RX;
            ph_r <= TWDPL_P_OP;
            bit_r <= 4'h0;
            cmd_active_r <= 1'b1;
            ack_fail_r <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            case (st_r)
                TWDPL_RX: begin
                    if (scl_r && bit_r < `TWDPL_PAR_IDX) begin
                        sh_r <= {sh_r[6:0], sda};
                        bit_r <= bit_r + 4'h1;
                    end else if (scl_r) begin
                        bit_r <= `TWDPL_ACK_IDX;
                        st_r <= TWDPL_RACK;
                        sda_oe <= 1'b0;
                        if (rx_ok) begin
                            sda_oe <= 1'b0;
                        end
                        ph_r <= rx_ok ? ph_r : ph_r;
                        tx_r <= rx_ok ? 8'h01 : 8'h00; // ok flag for ack slot
                    end else if (scl_f) begin
                        // the ack only stands through the tenth clock; let go before the next bit
                        sda_oe <= 1'b0;
                    end
                end
                TWDPL_RACK: begin
                    if (scl_f) begin
                        sda_oe <= tx_r[0];
                    end else if (scl_r) begin
                        st_r <= TWDPL_RX;
                        bit_r <= 4'h0;
                        if (tx_r[0]) begin
                            case (ph_r)
                                TWDPL_P_OP: begin
                                    cmd_r <= sh_r;
                                    ph_r <= TWDPL_P_ADDR;
                                end
                                TWDPL_P_ADDR: begin
                                    addr_r <= sh_r[MEM_AW-1:0];
                                    ph_r <= TWDPL_P_DATA;
                                    if (cmd_r == `TWDPL_CMD_OP_RD) begin
                                        st_r <= TWDPL_TX;
                                        tx_r <= mem_r[sh_r[MEM_AW-1:0]];
                                    end
                                end
                                default: begin
                                    addr_r <= addr_r + 1'b1;
                                end
                            endcase
                        end
                    end else if (~scl) begin
                        sda_oe <= tx_r[0];
                    end
                end
                TWDPL_TX: begin
                    // data changes only while scl is low
                    if (scl_f || (bit_r == 4'h0 && ~scl && !sda_oe && tx_r[7])) begin
                        if (bit_r < `TWDPL_DATA_BITS) begin
                            sda_oe <= ~tx_r[7 - bit_r[2:0]];
                        end else begin
                            sda_oe <= ~(^tx_r); // a one parity bit is a release
                        end
                    end else if (scl_r) begin
                        bit_r <= bit_r + 4'h1;
                        if (bit_r == `TWDPL_PAR_IDX) begin
                            st_r <= TWDPL_TACK;
                        end
                    end
                end
                TWDPL_TACK: begin
                    if (scl_f && bit_r == `TWDPL_PAR_IDX + 4'h1) begin
                        sda_oe <= 1'b0; // release for the host ack
                    end else if (scl_r) begin
                        ack_fail_r <= sda;
                        st_r <= sda ? TWDPL_IDLE : TWDPL_TX;
                        bit_r <= 4'h0;
                        addr_r <= addr_r + 1'b1;
                        tx_r <= mem_r[addr_r + 1'b1];
                    end
                end
                default: ;
            endcase
        end
    end

    // program memory write: each accepted data byte of a write command
    always_ff @(posedge ref_clk) begin
        if (wr_ack_hit(st_r, scl_r, tx_r[0], ph_r, cmd_r)) begin
            mem_r[addr_r] <= sh_r;
        end
    end

    // clock stretch: hold scl low a few cycles after each write-data ack
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_r <= 4'h0;
            scl_oe <= 1'b0;
            mem_busy_r <= 1'b0;
        end else if (wr_ack_hit(st_r, scl_r, tx_r[0], ph_r, cmd_r)) begin
            wait_r <= 4'(`TWDPL_TSETUP_CYC) + 4'h4;
            mem_busy_r <= 1'b1;
        end else if (wait_r != 4'h0 && ~scl) begin
            scl_oe <= 1'b1;
            wait_r <= wait_r - 4'h1;
        end else if (wait_r == 4'h0) begin
            scl_oe <= 1'b0;
            mem_busy_r <= 1'b0;
        end
    end

    // guards on the ack slot, the data line while receiving, parity, error path and stretch
    a_ack_on_ok: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_r == TWDPL_RACK && scl_f && tx_r[0] && !stop && !start) |=> sda_oe)
        else $error("ack not driven for good packet");
    a_rx_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_r == TWDPL_RX && scl_f && !stop && !start) |=> !sda_oe)
        else $error("data line held while receiving");
    a_tx_parity: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_r == TWDPL_TX && scl_f && bit_r == `TWDPL_DATA_BITS && !stop && !start)
        |=> sda_oe != (^tx_r))
        else $error("sent parity bit not even");
    a_fail_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (st_r == TWDPL_TACK && scl_r && sda && !stop && !start)
        |=> ack_fail_r && st_r == TWDPL_IDLE)
        else $error("ack failure not handled");
    a_stop_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
        stop |=> st_r == TWDPL_IDLE && !sda_oe)
        else $error("stop did not end command");
    a_scl_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
        scl_oe |-> mem_busy_r)
        else $error("scl held without wait");
endmodule
`default_nettype wire

// File: twdpl_defs.svh
// constants for the two-wire debug packet link: packet layout and timing counts
// assumes a 200 mhz ref_clk; included by the design, not by the package
`ifndef TWDPL_DEFS_SVH
`define TWDPL_DEFS_SVH
`define TWDPL_PKT_BITS      4'd10
`define TWDPL_DATA_BITS     4'd8
`define TWDPL_PAR_IDX       4'd8
`define TWDPL_ACK_IDX       4'd9
`define TWDPL_CLK_PERIOD_NS 5
`define TWDPL_TSETUP_NS     10
`define TWDPL_TSETUP_CYC    ((`TWDPL_TSETUP_NS + `TWDPL_CLK_PERIOD_NS - 1) / `TWDPL_CLK_PERIOD_NS)
`define TWDPL_CMD_OP_RD     8'h01
`define TWDPL_CMD_OP_WR     8'h02
`endif

// File: twdpl_pkg.sv
// types for the two-wire debug packet link
// assumes twdpl_defs.svh is on the include path
`default_nettype none
package twdpl_pkg;
    typedef enum logic [2:0] {
        TWDPL_IDLE = 3'b000,
        TWDPL_RX   = 3'b001,
        TWDPL_RACK = 3'b010,
        TWDPL_TX   = 3'b011,
        TWDPL_TACK = 3'b100
    } twdpl_state_t;
    typedef enum logic [1:0] {
        TWDPL_P_OP   = 2'b00,
        TWDPL_P_ADDR = 2'b01,
        TWDPL_P_DATA = 2'b10
    } twdpl_phase_t;
endpackage
`default_nettype wire

// File: twdpl_host.sv
// host model for the debug link: drives the clock and data lines open-drain
// assumes the bench resolves both lines as wired-and with pull-ups
`default_nettype none
module twdpl_host (
    input  wire logic scl,
    input  wire logic sda,
    output var  logic scl_pull,
    output var  logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 32; // half of the 64 ns link clock
    // idle: both lines released, the pull-ups hold them high
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // start: data falls while the clock is high
    task automatic start_cond();
        sda_pull = 1'b1;
        #(HALF / 2);
        scl_pull = 1'b1;
        #(HALF / 2);
    endtask
    // stop: data rises while the clock is high
    task automatic stop_cond();
        scl_pull = 1'b1;
        #(HALF / 2);
        sda_pull = 1'b1;
        #(HALF / 2);
        scl_pull = 1'b0;
        wait (scl === 1'b1);
        #(HALF / 2);
        sda_pull = 1'b0;
        #HALF;
    endtask
    // one bit: data moves only while the clock is low, stretch honoured
    task automatic bit_io(input logic drv, output logic seen);
        scl_pull = 1'b1;
        #(HALF / 2);
        sda_pull = ~drv; // a one is a release, never a drive high
        #(HALF / 2);
        scl_pull = 1'b0;
        wait (scl === 1'b1);
        #(HALF / 2);
        seen = sda;
        #(HALF / 2);
    endtask
    // eight data bits msb first, even parity, then the receiver's ack
    task automatic send_byte(input logic [7:0] d, input logic bad, output logic ack);
        logic unused;
        for (int i = 7; i >= 0; i--) bit_io(d[i], unused);
        bit_io((^d) ^ bad, unused);
        bit_io(1'b1, ack);
    endtask
    // receive a byte and parity, then answer the ack as asked
    task automatic recv_byte(output logic [7:0] d, output logic p, input logic ack);
        logic unused;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, p);
        bit_io(ack, unused);
    endtask
endmodule
`default_nettype wire

// File: twdpl_link_tb.sv
// self-checking bench for the device end of the debug link
// assumes twdpl_link and twdpl_host; wires resolved here as wired-and
`default_nettype none
module twdpl_link_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk, rst_b, scl_oe, sda_oe, cmd_active_r, ack_fail_r, mem_busy_r;
    logic       h_scl, h_sda, ack, p;
    logic [7:0] d;
    int         bad_count = 0;
    int         n_checks = 0;
    wire logic  scl_w = ~(scl_oe | h_scl);
    wire logic  sda_w = ~(sda_oe | h_sda);
    // rows: byte, corrupt parity, expected ack
    logic [9:0] rows [5] = '{{8'h02, 2'b00}, {8'h10, 2'b00}, {8'ha5, 2'b00},
                             {8'h3c, 2'b00}, {8'h77, 2'b11}};
    twdpl_link u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_w), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_oe(sda_oe), .cmd_active_r(cmd_active_r),
        .ack_fail_r(ack_fail_r), .mem_busy_r(mem_busy_r));
    twdpl_host u_host (.scl(scl_w), .sda(sda_w), .scl_pull(h_scl), .sda_pull(h_sda));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // send one byte and compare the ack that came back
    task automatic xfer(input logic [7:0] b, input logic bad, input logic exp);
        u_host.send_byte(b, bad, ack);
        chk(10'(ack), 10'(exp));
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the whole run is some 14 packets of 640 ns; far above that means a hang
    initial begin
        #80000;
        bad_count++;
        end_of_test();
    end
    initial begin
        rst_b = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk({5'h0, cmd_active_r, ack_fail_r, mem_busy_r, scl_oe, sda_oe}, 10'h0);
        rst_b = 1'b1;
        repeat (8) @(negedge ref_clk);
        // failed opcode packet, then stop and the same command again
        u_host.start_cond();
        xfer(8'h02, 1'b1, 1'b1);
        u_host.stop_cond();
        u_host.start_cond();
        #20;
        chk(10'(cmd_active_r), 10'h1);
        foreach (rows[i]) xfer(rows[i][9:2], rows[i][1], rows[i][0]);
        u_host.stop_cond();
        #20;
        chk(10'(cmd_active_r), 10'h0);
        // one more write: busy after the data ack, scl held low once the host drops it
        u_host.start_cond();
        xfer(8'h02, 1'b0, 1'b0);
        xfer(8'h20, 1'b0, 1'b0);
        xfer(8'h5a, 1'b0, 1'b0);
        chk(10'(mem_busy_r), 10'h1);
        fork
            u_host.stop_cond();
            begin
                #24;
                chk(10'(scl_oe), 10'h1);
            end
        join
        chk(10'(mem_busy_r), 10'h0);
        // read back, the last byte refused by the host
        u_host.start_cond();
        xfer(8'h01, 1'b0, 1'b0);
        xfer(8'h10, 1'b0, 1'b0);
        u_host.recv_byte(d, p, 1'b0);
        chk(10'(d), 10'ha5);
        chk(10'(p), 10'(^8'ha5));
        u_host.recv_byte(d, p, 1'b1);
        chk(10'(d), 10'h3c);
        u_host.stop_cond();
        #20;
        chk(10'(ack_fail_r), 10'h1);
        u_host.start_cond();
        #20;
        chk(10'(ack_fail_r), 10'h0);
        u_host.stop_cond();
        // reset in mid-command while the ack still stands: both lines let go at once
        u_host.start_cond();
        xfer(8'h01, 1'b0, 1'b0);
        @(negedge ref_clk);
        rst_b = 1'b0;
        @(negedge ref_clk);
        chk({7'h0, cmd_active_r, scl_oe, sda_oe}, 10'h0);
        rst_b = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk(10'(cmd_active_r), 10'h0);
        u_host.stop_cond();
        end_of_test();
    end
endmodule
`default_nettype wire
